// >>> verilog/ssp_pkg.sv
/*
  Shared constants, types and address-stepping functions for the three-wire
  sub-CPU serial register port. Used by both link ends; no clock of its own.
*/
package ssp_pkg;

  // ****************************************
  // Address byte layout
  // ****************************************
  localparam int SSP_SEL_BIT = 7;
  localparam int SSP_MODE_BIT = 6;
  localparam int SSP_REG_MSB = 5;
  localparam int SSP_REG_LSB = 1;
  localparam int SSP_DIR_BIT = 0;
  localparam int SSP_REG_W = SSP_REG_MSB - SSP_REG_LSB + 1;
  localparam logic [2:0] SSP_LAST_BIT = 3'h7;

  typedef logic [SSP_REG_W-1:0] ssp_reg_t;

  // ****************************************
  // Numeric stepping
  // ****************************************
  localparam ssp_reg_t SSP_REG_ZERO = 5'h00;
  localparam ssp_reg_t SSP_REG_ONE = 5'h01;
  localparam ssp_reg_t SSP_WRAP_LO = 5'h0f;
  localparam ssp_reg_t SSP_WRAP_HI = 5'h1f;

  // ****************************************
  // Table stepping: register numbering of the chains
  // ****************************************
  localparam ssp_reg_t SSP_CMD_PORT = 5'h00;
  localparam ssp_reg_t SSP_RD_A_FIRST = 5'h01;
  localparam ssp_reg_t SSP_RD_A_LAST = 5'h12;
  localparam ssp_reg_t SSP_RD_B_FIRST = 5'h13;
  localparam ssp_reg_t SSP_RD_B_LAST = 5'h18;
  localparam ssp_reg_t SSP_STAT_PORT = 5'h00;
  localparam ssp_reg_t SSP_WR_FIRST = 5'h01;
  localparam ssp_reg_t SSP_WR_JUMP_FROM = 5'h11;
  localparam ssp_reg_t SSP_WR_FIXED = 5'h15;
  localparam ssp_reg_t SSP_WR_RESUME = 5'h12;
  localparam ssp_reg_t SSP_WR_SKIP_FROM = 5'h14;
  localparam ssp_reg_t SSP_WR_SKIP_TO = 5'h16;
  localparam ssp_reg_t SSP_WR_LAST = 5'h1c;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SSP_CLK_NS = 5;
  localparam int SSP_SCL_HALF_NS = 80;
  localparam int SSP_SYNC_NS = 80;
  localparam int SSP_SCL_HALF_CYC = (SSP_SCL_HALF_NS + SSP_CLK_NS - 1) / SSP_CLK_NS;
  localparam int SSP_SYNC_CYC = (SSP_SYNC_NS + SSP_CLK_NS - 1) / SSP_CLK_NS;
  localparam int SSP_TIMER_W = 8;

  function automatic ssp_reg_t ssp_step_numeric(input ssp_reg_t a);
    ssp_reg_t r;
    r = ssp_reg_t'(a + SSP_REG_ONE);
    if (a == SSP_REG_ZERO || a == SSP_WRAP_LO || a == SSP_WRAP_HI) begin
      r = SSP_REG_ZERO;
    end
    return r;
  endfunction : ssp_step_numeric

  function automatic ssp_reg_t ssp_step_read(input ssp_reg_t a);
    ssp_reg_t r;
    r = SSP_CMD_PORT;
    if ((a >= SSP_RD_A_FIRST && a < SSP_RD_A_LAST) ||
        (a >= SSP_RD_B_FIRST && a < SSP_RD_B_LAST)) begin
      r = ssp_reg_t'(a + SSP_REG_ONE);
    end
    return r;
  endfunction : ssp_step_read

  function automatic ssp_reg_t ssp_step_write(input ssp_reg_t a);
    ssp_reg_t r;
    r = SSP_STAT_PORT;
    if (a == SSP_WR_JUMP_FROM) begin
      r = SSP_WR_FIXED;
    end else if (a == SSP_WR_FIXED) begin
      r = SSP_WR_RESUME;
    end else if (a == SSP_WR_SKIP_FROM) begin
      r = SSP_WR_SKIP_TO;
    end else if (a >= SSP_WR_FIRST && a < SSP_WR_LAST) begin
      r = ssp_reg_t'(a + SSP_REG_ONE);
    end
    return r;
  endfunction : ssp_step_write

  function automatic ssp_reg_t ssp_step_addr(input ssp_reg_t a, input logic table_mode,
                                             input logic is_read);
    ssp_reg_t r;
    r = ssp_step_numeric(a);
    if (table_mode) begin
      r = is_read ? ssp_step_read(a) : ssp_step_write(a);
    end
    return r;
  endfunction : ssp_step_addr

endpackage : ssp_pkg

// >>> verilog/ssp_link_if.sv
/*
  Three-wire link between the sub-CPU end and the device end.
  Assumes both ends only ever pull the data line low; the wire level is
  resolved here from the two output enables.
*/
`timescale 1ns/1ps
interface ssp_link_if;
  logic frame_sync_line;
  logic scl;
  logic sda;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic host_sda_out;
  logic host_sda_oe;

  // Open-collector wired AND with a pull-up
  assign sda = ~((dev_sda_oe & ~dev_sda_out) | (host_sda_oe & ~host_sda_out));

  modport dev (input frame_sync_line, input scl, input sda, output dev_sda_out,
               output dev_sda_oe);
  modport host (output frame_sync_line, output scl, input sda, output host_sda_out,
                output host_sda_oe);
endinterface : ssp_link_if

// >>> verilog/ssp_dev.sv
/*
  Device end of the sub-CPU serial register port: decodes the address
  byte, moves data bytes to and from a 5-bit addressed register set.
  Assumes the register set answers reg_rdata_in combinationally from
  reg_addr_out in the cycle reg_rd_out is high. All link pins are
  asynchronous and are synchronised here.
*/
// How it works
// - Three wires: sync, clock, open-collector data
// - Sync pulse, then 8-bit address byte
// - Bit 7 set: stay silent, change nothing
// - Bits 5..1 load the address register
// - Bit 0 clear: store each data byte
// - Bit 0 set: drive register bytes out
// - Step the address after every data byte
// - Numeric mode: 1-14, 16-30 add one
// - Numeric mode: 15, 31 wrap; 0 stays
// - Table mode read: fixed read chain
// - Table mode write: fixed write chain
// - Mode bit governs the whole command
`timescale 1ns/1ps
module ssp_dev
  import ssp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Serial link
  ssp_link_if.dev link,
  // Register set access
  output logic [SSP_REG_W-1:0] reg_addr_out,
  output logic reg_wr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_rd_out,
  input wire logic [7:0] reg_rdata_in,
  // Status
  output logic selected_out
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {
    P_WAIT,
    P_ADDR,
    P_WRITE,
    P_READ
  } ssp_phase_t;

  typedef struct packed {
    logic frame_sync_m;
    logic frame_sync_q;
    logic scl_m;
    logic scl_q;
    logic scl_p;
    logic sda_m;
    logic sda_q;
    ssp_phase_t phase;
    logic mode;
    logic dir;
    ssp_reg_t addr;
    logic [2:0] cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic drive_low;
    logic load;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] wdata;
  } ssp_dev_state_t;

  ssp_dev_state_t st;
  ssp_dev_state_t next_st;

  // Clock and data wires idle high; starting their synchronisers there keeps a
  // false rising edge out of the first cycles after reset
  localparam ssp_dev_state_t ST_RESET = '{scl_m: 1'b1, scl_q: 1'b1, scl_p: 1'b1,
    sda_m: 1'b1, sda_q: 1'b1, phase: P_WAIT, default: '0};

  logic rise;
  logic fall;
  logic [7:0] full_byte;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.wr_stb = 1'b0;
    next_st.rd_stb = 1'b0;

    next_st.frame_sync_m = link.frame_sync_line;
    next_st.frame_sync_q = st.frame_sync_m;
    next_st.scl_m = link.scl;
    next_st.scl_q = st.scl_m;
    next_st.scl_p = st.scl_q;
    next_st.sda_m = link.sda;
    next_st.sda_q = st.sda_m;

    // The third stage keeps the last level, so each edge shows for one cycle
    rise = st.scl_q & ~st.scl_p;
    fall = ~st.scl_q & st.scl_p;
    // Byte as it stands once the current bit is shifted in
    full_byte = {st.rx[6:0], st.sda_q};

    // step after write
    // A write steps one cycle after its strobe so the strobe sees the old address
    if (st.wr_stb) begin
      next_st.addr = ssp_step_addr(st.addr, st.mode, st.dir);
    end

    // Read data arrives in the cycle the read strobe is out; its first bit
    // goes out now, the later bits at each following fall
    if (st.load) begin
      next_st.load = 1'b0;
      next_st.tx = {reg_rdata_in[6:0], 1'b0};
      next_st.drive_low = ~reg_rdata_in[7];
    end

    if (st.frame_sync_q) begin
      // sync opens command
      // The sync level holds the port at frame start and frees the data line
      next_st.phase = P_ADDR;
      next_st.cnt = 3'h0;
      next_st.drive_low = 1'b0;
      next_st.load = 1'b0;
    end else if (rise && st.phase != P_WAIT) begin
      next_st.rx = full_byte;
      next_st.cnt = st.cnt + 3'h1;
      if (st.cnt == SSP_LAST_BIT) begin
        case (st.phase)
          P_ADDR: begin
            if (full_byte[SSP_SEL_BIT]) begin
              // Waiting drops every later bit of a foreign command until the next sync
              // foreign command ignored
              next_st.phase = P_WAIT;
            end else begin
              next_st.addr = full_byte[SSP_REG_MSB:SSP_REG_LSB];
              next_st.mode = full_byte[SSP_MODE_BIT];
              next_st.dir = full_byte[SSP_DIR_BIT];
              next_st.phase = full_byte[SSP_DIR_BIT] ? P_READ : P_WRITE;
            end
          end
          P_WRITE: begin
            next_st.wr_stb = 1'b1;
            next_st.wdata = full_byte;
          end
          P_READ: begin
            next_st.addr = ssp_step_addr(st.addr, st.mode, st.dir);
            // Line is freed between bytes, so the master may stop here
            next_st.drive_low = 1'b0;
          end
          default: begin
            next_st.phase = P_WAIT;
          end
        endcase
      end
    end else if (fall && st.phase == P_READ) begin
      if (st.cnt == 3'h0) begin
        // Fetch only when a byte is really clocked, so pop-type registers
        // lose nothing when the master stops after the previous byte
        next_st.rd_stb = 1'b1;
        next_st.load = 1'b1;
      end else begin
        next_st.drive_low = ~st.tx[7];
        next_st.tx = {st.tx[6:0], 1'b0};
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_addr_out = st.addr;
  assign reg_wr_out = st.wr_stb;
  assign reg_wdata_out = st.wdata;
  assign reg_rd_out = st.rd_stb;
  // Stays high after the last byte until the next sync
  assign selected_out = (st.phase == P_WRITE) || (st.phase == P_READ);

  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = st.drive_low;

endmodule : ssp_dev

// >>> verilog/ssp_host.sv
/*
  Sub-CPU end of the serial register port: makes the sync pulse and the
  bit clock from the system clock and shifts one command per request.
  Assumes the user holds wdata_in valid whenever a write command runs.
*/
`timescale 1ns/1ps
module ssp_host
  import ssp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Serial link
  ssp_link_if.host link,
  // Command request
  input wire logic start_in,
  input wire logic [7:0] addr_byte_in,
  input wire logic [7:0] count_in,
  output logic busy_out,
  // Write data
  input wire logic [7:0] wdata_in,
  output logic wdata_take_out,
  // Read data
  output logic [7:0] rdata_out,
  output logic rdata_valid_out
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {
    H_IDLE,
    H_SYNC,
    H_GAP,
    H_LOW,
    H_HIGH
  } ssp_host_phase_t;

  typedef struct packed {
    logic sda_m;
    logic sda_q;
    ssp_host_phase_t phase;
    logic frame_sync;
    logic scl;
    logic drive_low;
    logic [SSP_TIMER_W-1:0] timer;
    logic [2:0] bitn;
    logic [7:0] left;
    logic [7:0] tx;
    logic [7:0] rx;
    logic rd;
    logic first;
    logic take;
    logic [7:0] rdata;
    logic rvalid;
  } ssp_host_state_t;

  localparam logic [SSP_TIMER_W-1:0] HALF_LOAD = SSP_TIMER_W'(SSP_SCL_HALF_CYC - 1);
  localparam logic [SSP_TIMER_W-1:0] SYNC_LOAD = SSP_TIMER_W'(SSP_SYNC_CYC - 1);

  ssp_host_state_t st;
  ssp_host_state_t next_st;
  logic [7:0] nbyte;
  logic [7:0] sampled;

  always_comb begin
    next_st = st;
    next_st.take = 1'b0;
    next_st.rvalid = 1'b0;
    next_st.sda_m = link.sda;
    next_st.sda_q = st.sda_m;
    nbyte = {st.tx[6:0], 1'b0};
    sampled = {st.rx[6:0], st.sda_q};
    if (st.timer != '0) begin
      next_st.timer = st.timer - 1'b1;
    end
    case (st.phase)
      H_IDLE: begin
        if (start_in) begin
          next_st.phase = H_SYNC;
          next_st.frame_sync = 1'b1;
          // Bit clock stands high through sync and gap, also after reset
          next_st.scl = 1'b1;
          next_st.timer = SYNC_LOAD;
          next_st.tx = addr_byte_in;
          next_st.left = count_in;
          next_st.rd = addr_byte_in[SSP_DIR_BIT];
          next_st.first = 1'b1;
          next_st.bitn = 3'h0;
        end
      end
      H_SYNC: begin
        if (st.timer == '0) begin
          next_st.frame_sync = 1'b0;
          next_st.phase = H_GAP;
          next_st.timer = HALF_LOAD;
        end
      end
      H_GAP: begin
        if (st.timer == '0) begin
          next_st.phase = H_LOW;
          next_st.scl = 1'b0;
          next_st.drive_low = ~st.tx[7];
          next_st.timer = HALF_LOAD;
        end
      end
      H_LOW: begin
        if (st.timer == '0) begin
          next_st.phase = H_HIGH;
          next_st.scl = 1'b1;
          next_st.rx = sampled;
          next_st.timer = HALF_LOAD;
        end
      end
      H_HIGH: begin
        if (st.timer == '0) begin
          next_st.phase = H_LOW;
          next_st.scl = 1'b0;
          next_st.timer = HALF_LOAD;
          next_st.bitn = st.bitn + 3'h1;
          if (st.bitn == SSP_LAST_BIT) begin
            next_st.first = 1'b0;
            if (!st.first && st.rd) begin
              next_st.rdata = st.rx;
              next_st.rvalid = 1'b1;
            end
            nbyte = 8'hff;
            if (!st.rd) begin
              nbyte = wdata_in;
            end
            if (st.left == 8'h00) begin
              next_st.phase = H_IDLE;
              next_st.scl = 1'b1;
              nbyte = 8'hff;
            end else begin
              next_st.left = st.left - 8'h01;
              next_st.take = ~st.rd;
            end
          end
          next_st.tx = nbyte;
          next_st.drive_low = ~nbyte[7];
        end
      end
      default: begin
        next_st.phase = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy_out = (st.phase != H_IDLE);
  assign wdata_take_out = st.take;
  assign rdata_out = st.rdata;
  assign rdata_valid_out = st.rvalid;
  assign link.frame_sync_line = st.frame_sync;
  // Idle level of the bit clock is high once out of reset
  assign link.scl = st.scl | (st.phase == H_IDLE);
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe = st.drive_low;

endmodule : ssp_host

// >>> tb/ssp_link_asserts.sv
/*
  Checker on the three link wires between the two ends.
  Assumes the signals of one ssp_link_if and the system clock domain.
*/
`timescale 1ns/1ps
module ssp_link_asserts (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Link wires
  input wire logic frame_sync_line,
  input wire logic scl,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic host_sda_out,
  input wire logic host_sda_oe
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);

  // ****************************************
  // Wire and framing checks
  // ****************************************
  dev_pull_low_a: assert property (dev_sda_oe |-> !dev_sda_out)
    else $error("device end drives data high");
  host_pull_low_a: assert property (host_sda_oe |-> !host_sda_out)
    else $error("sub-CPU end drives data high");
  single_driver_a: assert property (dev_sda_oe |-> !host_sda_oe)
    else $error("both ends pull the data line");
  sync_width_a: assert property ($rose(frame_sync_line) |-> frame_sync_line[*8] ##1
    frame_sync_line[*7] ##[1:2] !frame_sync_line)
    else $error("sync pulse width wrong");
  sync_idle_a: assert property (frame_sync_line |-> scl && !dev_sda_oe)
    else $error("clock or device data active in sync");
  bit_low_a: assert property ($fell(scl) |-> !scl[*8] ##1 !scl[*7] ##[1:2] scl)
    else $error("bit clock low phase wrong");
  host_hold_a: assert property ($rose(scl) |-> $stable(host_sda_oe) ##1 $stable(host_sda_oe))
    else $error("sub-CPU data moved at sample edge");
  dev_launch_a: assert property ($rose(dev_sda_oe) |-> !scl && !frame_sync_line)
    else $error("device data launched outside low phase");

  cover property ($rose(frame_sync_line));
  cover property ($rose(dev_sda_oe));
  cover property ($rose(host_sda_oe));
endmodule : ssp_link_asserts

// >>> tb/subcpu_serial_register_port_tb.sv
/*
  Bench joining both link ends; a register array answers the device.
  Assumes the package constants and the hand-over timing of both ends.
*/
`timescale 1ns/1ps
module subcpu_serial_register_port_tb;
  import ssp_pkg::*;
  logic clk_sys_in, arst_n_in, start, busy, take, rvalid, wr, rd, sel;
  logic [7:0] abyte, cnt, wdata, rdata, wdat, mem [32];
  logic [4:0] raddr;
  logic [15:0] e;
  logic [15:0] expq [$];
  logic [7:0] wdq [$];
  int failures, tests_run, rd_exp, rd_seen;
  // Entries: address byte, data byte count
  localparam logic [15:0] TBL [14] = '{
    16'h1a04, 16'h3c03, 16'h1d03, 16'h0102,
    16'h6303, 16'h6f03, 16'h4102,
    16'h6007, 16'h7603, 16'h4002,
    16'h2303,
    16'h9a02, 16'h9b02,
    16'h1a00};

  ssp_link_if ssp_link_if_inst ();
  ssp_dev ssp_dev_inst (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .link(ssp_link_if_inst.dev), .reg_addr_out(raddr), .reg_wr_out(wr),
    .reg_wdata_out(wdat), .reg_rd_out(rd), .reg_rdata_in(mem[raddr]), .selected_out(sel));
  ssp_host ssp_host_inst (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .link(ssp_link_if_inst.host), .start_in(start), .addr_byte_in(abyte),
    .count_in(cnt), .busy_out(busy), .wdata_in(wdata), .wdata_take_out(take),
    .rdata_out(rdata), .rdata_valid_out(rvalid));
  ssp_link_asserts ssp_link_asserts_inst (.clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in), .frame_sync_line(ssp_link_if_inst.frame_sync_line),
    .scl(ssp_link_if_inst.scl),
    .dev_sda_out(ssp_link_if_inst.dev_sda_out), .dev_sda_oe(ssp_link_if_inst.dev_sda_oe),
    .host_sda_out(ssp_link_if_inst.host_sda_out),
    .host_sda_oe(ssp_link_if_inst.host_sda_oe));

  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic tick;
    @(posedge clk_sys_in);
    #1;
  endtask : tick

  // Own model of address stepping, kept apart from the design's
  function automatic logic [4:0] nx(input logic [4:0] a, input logic m, input logic rd);
    if (!m) return (a == 5'h00 || a == 5'h0f || a == 5'h1f) ? 5'h00 : a + 5'h01;
    if (rd) return ((a >= 5'h01 && a < 5'h12) || (a >= 5'h13 && a < 5'h18)) ? a + 5'h01 : 5'h00;
    if (a == 5'h11) return 5'h15;
    if (a == 5'h15) return 5'h12;
    if (a == 5'h14) return 5'h16;
    return (a >= 5'h01 && a < 5'h1c) ? a + 5'h01 : 5'h00;
  endfunction : nx

  task automatic wait_idle;
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 20000) begin
      tick;
      i++;
    end
    if (i >= 20000) begin
      failures++;
      $display("[ERR] %0t sub-CPU end stuck busy", $time);
      tally_and_finish;
    end
  endtask : wait_idle

  // Notes expected results, then issues one command
  task automatic cmd(input logic [7:0] ab, input logic [7:0] n);
    logic [4:0] a;
    logic [7:0] d;
    wait_idle;
    wdq.delete();
    a = ab[5:1];
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      if (ab[7] && ab[0]) expq.push_back(16'h80ff);
      else if (!ab[7] && ab[0]) expq.push_back({8'h80, mem[a]});
      else if (!ab[7]) expq.push_back({3'h0, a, d});
      if (!ab[7] && ab[0]) rd_exp++;
      if (!ab[0]) wdq.push_back(d);
      a = nx(a, ab[6], ab[0]);
    end
    wdata = (wdq.size() > 0) ? wdq[0] : 8'h00;
    abyte = ab;
    cnt = n;
    start = 1'b1;
    tick;
    start = 1'b0;
  endtask : cmd

  // Next write byte once the current one is taken
  always @(posedge clk_sys_in) begin
    if (take === 1'b1) begin
      #1;
      if (wdq.size() > 0) void'(wdq.pop_front());
      wdata = (wdq.size() > 0) ? wdq[0] : 8'h00;
    end
  end

  // Result watcher: an unexpected result meets a value no note can hold
  always @(posedge clk_sys_in) begin
    if (rd === 1'b1) rd_seen++;
    if (wr === 1'b1 || rd === 1'b1) check({15'h0000, sel}, 16'h0001);
    if (wr === 1'b1 || rvalid === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : 16'hdead;
      if (wr === 1'b1) check({3'h0, raddr, wdat}, e);
      if (rvalid === 1'b1) check({8'h80, rdata}, e);
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    failures = 0;
    tests_run = 0;
    rd_exp = 0;
    rd_seen = 0;
    start = 1'b0;
    abyte = 8'h00;
    cnt = 8'h00;
    wdata = 8'h00;
    arst_n_in = 1'b0;
    void'($urandom(32'hf8495056));
    foreach (mem[i]) mem[i] = 8'($urandom);
    repeat (12) @(posedge clk_sys_in);
    #1;
    arst_n_in = 1'b1;
    foreach (TBL[i]) begin
      cmd(TBL[i][15:8], TBL[i][7:0]);
      $display("test %0d done", i);
    end
    repeat (4) cmd({1'b0, 7'($urandom)}, 8'($urandom_range(1, 3)));
    $display("random commands done");
    wait_idle;
    repeat (200) tick;
    check(16'(expq.size()), 16'h0000);
    check(16'(rd_seen), 16'(rd_exp));
    tally_and_finish;
  end
endmodule : subcpu_serial_register_port_tb
